// [inc/uhpf_pkg.sv]
/*
 * shared constants of the host pipe flag and control block:
 * register bases, bit positions, strobe masks and reset values.
 * assumes a 12-bit byte address from an APB slave port.
 */
package uhpf_pkg;

    // ------------------------------------------------------------------
    // pipe count and register map
    // ------------------------------------------------------------------
    localparam int          UHPF_NPIPE       = 7;
    localparam logic [11:0] UHPF_STAT_BASE   = 12'h530;
    localparam logic [11:0] UHPF_ACK_BASE    = 12'h560;
    localparam logic [11:0] UHPF_FORCE_BASE  = 12'h590;
    localparam logic [11:0] UHPF_VIEW_BASE   = 12'h5c0;
    localparam logic [11:0] UHPF_CSET_BASE   = 12'h5f0;
    localparam logic [11:0] UHPF_CCLR_BASE   = 12'h620;
    localparam logic [11:0] UHPF_STRIDE      = 12'h004;

    // ------------------------------------------------------------------
    // bit positions of flags and control bits
    // ------------------------------------------------------------------
    localparam int UHPF_B_IN      = 0;
    localparam int UHPF_B_OUT     = 1;
    localparam int UHPF_B_SETUP   = 2;
    localparam int UHPF_B_PIPE_FAULT_STATUS    = 3;
    localparam int UHPF_B_NAK     = 4;
    localparam int UHPF_B_OVER    = 5;
    localparam int UHPF_B_STALL   = 6;
    localparam int UHPF_B_SHORT   = 7;
    localparam int UHPF_B_BUSY    = 12;
    localparam int UHPF_B_HANDOFF = 14;
    localparam int UHPF_B_DMA     = 16;
    localparam int UHPF_B_HOLD    = 17;
    localparam int UHPF_B_TOGGLE  = 18;

    // ------------------------------------------------------------------
    // strobe masks and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] UHPF_FLAG_MASK   = 32'h0000_10ff;
    localparam logic [31:0] UHPF_ACK_MASK    = 32'h0000_00f7;
    localparam logic [31:0] UHPF_IEN_MASK    = 32'h0000_10ff;
    localparam logic [31:0] UHPF_CSET_MASK   = 32'h0007_10ff;
    localparam logic [31:0] UHPF_CCLR_MASK   = 32'h0003_50ff;
    localparam logic [31:0] UHPF_VIEW_MASK   = 32'h0007_50ff;
    localparam logic [31:0] UHPF_CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] UHPF_FLAG_RESET  = 32'h0000_0000;

endpackage

// [rtl/uhpf_pipe_flags.sv]
/*
 * per-pipe interrupt flags and pipe control bits of a usb host
 * controller, reached over apb, with one level interrupt output.
 * assumes all inputs synchronous to pclk; the transaction engine
 * drives the event pulses and pipe type levels, one bit per pipe.
 */
// Local design decision: register access over APB.
`timescale 1ns/1ns

// Behaviour
// - writing one to an acknowledge bit clears the matching pipe flag, bits 0-2 and 4-7.
// - zero strobe bits change nothing; strobe registers read as zero.
// - writing one to a force bit sets the matching flag, bits 0-7.
// - force bit 12 sets the busy bank count flag.
// - bits 2 and 6 carry two flags each, chosen by pipe type.
// - seven force and control registers, four bytes apart, at fixed bases.
// - enables change only through set and clear strobes; reset zero.
// - enable bits 0-7 sit at the same places as their flags.
// - busy bank count enable at control bit 12, own strobes.
// - out or setup bank free sets handoff bit 14 with its flag.
// - stored in data sets handoff bit with flag; clear advances bank.
// - while hold bit 17 is set the pipe makes no requests.
// - unconfigured, stall on a non-iso pipe, pipe error, or in budget done sets hold.
// - pipe reset or pipe enable forces the hold bit.
// - toggle restart bit 18 set by strobe, cleared when restart done.
// - control bit 16 blocks dma requests while a pipe irq pends.
// - a flag raises the interrupt only while its enable is set.
// - acknowledge registers are write-only at 0x0560, read as zero.
module uhpf_pipe_flags
    import uhpf_pkg::*;
#(
    parameter int NP = UHPF_NPIPE
) (
    // clock, reset, enable
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            pce,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // pipe type levels
    input  wire logic [NP-1:0]   pipe_is_in,
    input  wire logic [NP-1:0]   pipe_is_control,
    input  wire logic [NP-1:0]   pipe_is_iso,
    input  wire logic [NP-1:0]   pipe_unconfigured,
    // transaction engine events, one-cycle pulses
    input  wire logic [NP-1:0]   ev_in_received,
    input  wire logic [NP-1:0]   ev_out_free,
    input  wire logic [NP-1:0]   ev_setup_free,
    input  wire logic [NP-1:0]   ev_underflow,
    input  wire logic [NP-1:0]   ev_nak,
    input  wire logic [NP-1:0]   ev_overflow,
    input  wire logic [NP-1:0]   ev_stall,
    input  wire logic [NP-1:0]   ev_crc,
    input  wire logic [NP-1:0]   ev_short,
    input  wire logic [NP-1:0]   ev_busy_bank,
    input  wire logic [NP-1:0]   ev_in_budget_done,
    input  wire logic [NP-1:0]   ev_pipe_reset,
    input  wire logic [NP-1:0]   ev_pipe_enable,
    input  wire logic [NP-1:0]   ev_toggle_restart_done,
    // error source level from the error register
    input  wire logic [NP-1:0]   pipe_fault_status,
    // outputs to the transaction engine and interrupt controller
    output logic      [NP-1:0]   pipe_request_hold,
    output logic      [NP-1:0]   toggle_restart,
    output logic      [NP-1:0]   bank_release,
    output logic      [NP-1:0]   dma_request_blocked,
    output logic                 irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NP-1:0][31:0] flag;
        logic [NP-1:0][31:0] ctrl;
        logic [NP-1:0]       fault_q;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                irq;
        logic [NP-1:0]       hold;
        logic [NP-1:0]       toggle;
        logic [NP-1:0]       release_p;
        logic [NP-1:0]       dma_block;
    } uhpf_state_s;

    uhpf_state_s s;
    uhpf_state_s next_s;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic in_region(input logic [11:0] a,
                                       input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        in_region = (a >= base) && (off < 12'(NP * 4)) &&
                    (a[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] region_idx(input logic [11:0] a,
                                              input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        region_idx = off[4:2];
    endfunction

    logic       hit_stat;
    logic       hit_ack;
    logic       hit_force;
    logic       hit_view;
    logic       hit_cset;
    logic       hit_cclr;
    logic       mapped;
    logic [2:0] widx;
    logic       wr;
    logic       setup;

    assign hit_stat  = in_region(paddr, UHPF_STAT_BASE);
    assign hit_ack   = in_region(paddr, UHPF_ACK_BASE);
    assign hit_force = in_region(paddr, UHPF_FORCE_BASE);
    assign hit_view  = in_region(paddr, UHPF_VIEW_BASE);
    assign hit_cset  = in_region(paddr, UHPF_CSET_BASE);
    assign hit_cclr  = in_region(paddr, UHPF_CCLR_BASE);
    assign mapped    = hit_stat | hit_ack | hit_force | hit_view |
                       hit_cset | hit_cclr;
    assign widx      = hit_stat  ? region_idx(paddr, UHPF_STAT_BASE)  :
                       hit_ack   ? region_idx(paddr, UHPF_ACK_BASE)   :
                       hit_force ? region_idx(paddr, UHPF_FORCE_BASE) :
                       hit_view  ? region_idx(paddr, UHPF_VIEW_BASE)  :
                       hit_cset  ? region_idx(paddr, UHPF_CSET_BASE)  :
                                   region_idx(paddr, UHPF_CCLR_BASE);
    assign wr        = psel & penable & s.pready & pwrite;
    assign setup     = psel & ~penable;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] ack;
        logic [31:0] fset;
        logic [31:0] cset;
        logic [31:0] cclr;
        logic [31:0] hs;
        logic        pend;
        ack    = '0;
        fset   = '0;
        cset   = '0;
        cclr   = '0;
        hs     = '0;
        pend   = 1'b0;
        next_s = s;
        next_s.irq = 1'b0;
        for (int p = 0; p < NP; p++) begin
            // strobes: only ones act, zeros leave state alone
            ack  = (wr && hit_ack   && widx == 3'(p)) ?
                   pwdata & UHPF_ACK_MASK  : '0;
            fset = (wr && hit_force && widx == 3'(p)) ?
                   pwdata & UHPF_FLAG_MASK : '0;
            cset = (wr && hit_cset  && widx == 3'(p)) ?
                   pwdata & UHPF_CSET_MASK : '0;
            cclr = (wr && hit_cclr  && widx == 3'(p)) ?
                   pwdata & UHPF_CCLR_MASK : '0;
            // hardware flag events, shared bits chosen by pipe type
            hs = '0;
            hs[UHPF_B_IN]    = ev_in_received[p];
            hs[UHPF_B_OUT]   = ev_out_free[p];
            hs[UHPF_B_SETUP] = pipe_is_control[p] ? ev_setup_free[p]
                                                  : ev_underflow[p];
            hs[UHPF_B_NAK]   = ev_nak[p];
            hs[UHPF_B_OVER]  = ev_overflow[p];
            hs[UHPF_B_STALL] = pipe_is_iso[p] ? ev_crc[p]
                                              : ev_stall[p];
            hs[UHPF_B_SHORT] = ev_short[p];
            hs[UHPF_B_BUSY]  = ev_busy_bank[p];
            // set after clear so that a same-cycle event survives
            next_s.flag[p] = ((s.flag[p] & ~ack) | hs | fset) &
                             UHPF_FLAG_MASK;
            // force bits land on the flags above
            // error flag follows its source, drops when source clears
            next_s.fault_q[p] = pipe_fault_status[p];
            next_s.flag[p][UHPF_B_PIPE_FAULT_STATUS] = pipe_fault_status[p] |
                fset[UHPF_B_PIPE_FAULT_STATUS] |
                (s.flag[p][UHPF_B_PIPE_FAULT_STATUS] &
                 ~(s.fault_q[p] & ~pipe_fault_status[p]));
            // control bits: enables only through strobes
            next_s.ctrl[p] = ((s.ctrl[p] & ~cclr) | cset) &
                             UHPF_VIEW_MASK;
            // handoff set with its flag, per direction
            if (pipe_is_in[p] ? ev_in_received[p]
                              : (ev_out_free[p] | ev_setup_free[p])) begin
                next_s.ctrl[p][UHPF_B_HANDOFF] = 1'b1;
            end
            next_s.release_p[p] = cclr[UHPF_B_HANDOFF] &
                                  s.ctrl[p][UHPF_B_HANDOFF];
            // hardware reasons to hold the pipe
            if (pipe_unconfigured[p] || (ev_stall[p] && !pipe_is_iso[p]) ||
                next_s.flag[p][UHPF_B_PIPE_FAULT_STATUS] || ev_in_budget_done[p]) begin
                next_s.ctrl[p][UHPF_B_HOLD] = 1'b1;
            end
            if (ev_pipe_reset[p] || ev_pipe_enable[p]) begin
                next_s.ctrl[p][UHPF_B_HOLD] = 1'b1;
            end
            // toggle restart ends when the engine reports it done
            if (ev_toggle_restart_done[p] && !cset[UHPF_B_TOGGLE]) begin
                next_s.ctrl[p][UHPF_B_TOGGLE] = 1'b0;
            end
            next_s.hold[p]   = next_s.ctrl[p][UHPF_B_HOLD];
            next_s.toggle[p] = next_s.ctrl[p][UHPF_B_TOGGLE];
            // pending interrupt of this pipe
            pend = |(next_s.flag[p] & next_s.ctrl[p] &
                     UHPF_IEN_MASK);
            next_s.irq = next_s.irq | pend;
            next_s.dma_block[p] = pend &
                                  next_s.ctrl[p][UHPF_B_DMA];
        end
        // apb: answer in the first access cycle
        next_s.pready  = setup;
        next_s.pslverr = setup & ~mapped;
        next_s.prdata  = '0;
        if (setup && !pwrite && hit_stat) begin
            next_s.prdata = s.flag[widx];
        end else if (setup && !pwrite && hit_view) begin
            next_s.prdata = s.ctrl[widx];
        end
        if (!pce) begin
            next_s = s;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata              = s.prdata;
    assign pready              = s.pready;
    assign pslverr             = s.pslverr;
    assign pipe_request_hold   = s.hold;
    assign toggle_restart      = s.toggle;
    assign bank_release        = s.release_p;
    assign dma_request_blocked = s.dma_block;
    assign irq                 = s.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr0_ack;
    logic wr0_force;
    logic wr0_cset;
    logic wr0_cclr;
    logic any_pend;

    assign wr0_ack   = pce && wr && hit_ack   && widx == 3'd0;
    assign wr0_force = pce && wr && hit_force && widx == 3'd0;
    assign wr0_cset  = pce && wr && hit_cset  && widx == 3'd0;
    assign wr0_cclr  = pce && wr && hit_cclr  && widx == 3'd0;

    always_comb begin
        any_pend = 1'b0;
        for (int p = 0; p < NP; p++) begin
            any_pend = any_pend | (|(s.flag[p] & s.ctrl[p] & UHPF_IEN_MASK));
        end
    end

    property p_ack_clears;
        wr0_ack && pwdata[UHPF_B_NAK] && !ev_nak[0] |=> !s.flag[0][UHPF_B_NAK];
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("acknowledge did not clear the flag");

    property p_wo_reads_zero;
        pce && setup && !pwrite && (hit_ack || hit_force || hit_cset)
            ##1 penable |-> prdata == 32'h0000_0000;
    endproperty
    a_wo_reads_zero: assert property (p_wo_reads_zero)
        else $error("strobe register did not read as zero");

    property p_force_sets;
        wr0_force && pwdata[UHPF_B_OVER] |=> s.flag[0][UHPF_B_OVER];
    endproperty
    a_force_sets: assert property (p_force_sets)
        else $error("force bit did not set the flag");

    property p_force_busy;
        wr0_force && pwdata[UHPF_B_BUSY] && !wr0_ack
            |=> s.flag[0][UHPF_B_BUSY] [*1];
    endproperty
    a_force_busy: assert property (p_force_busy)
        else $error("busy bank force did not set its flag");

    property p_enable_stable;
        pce && !wr0_cset && !wr0_cclr
            |=> s.ctrl[0][7:0] == $past(s.ctrl[0][7:0]);
    endproperty
    a_enable_stable: assert property (p_enable_stable)
        else $error("enable changed without a strobe");

    property p_handoff_with_flag;
        pce && ev_out_free[0] && !pipe_is_in[0]
            |=> s.ctrl[0][UHPF_B_HANDOFF] && s.flag[0][UHPF_B_OUT];
    endproperty
    a_handoff_with_flag: assert property (p_handoff_with_flag)
        else $error("handoff bit not set with bank free flag");

    property p_stall_holds;
        pce && ev_stall[0] && !pipe_is_iso[0] && !wr0_cclr
            |=> pipe_request_hold[0];
    endproperty
    a_stall_holds: assert property (p_stall_holds)
        else $error("stall did not hold the pipe");

    property p_reset_holds;
        pce && (ev_pipe_reset[0] || ev_pipe_enable[0])
            |=> s.ctrl[0][UHPF_B_HOLD] && pipe_request_hold[0];
    endproperty
    a_reset_holds: assert property (p_reset_holds)
        else $error("pipe reset or enable did not hold the pipe");

    property p_toggle_done;
        pce && ev_toggle_restart_done[0] && !wr0_cset |=> !toggle_restart[0];
    endproperty
    a_toggle_done: assert property (p_toggle_done)
        else $error("toggle restart not cleared when done");

    property p_irq_gated;
        irq |-> any_pend;
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("interrupt without an enabled flag");

    property p_set_wins;
        wr0_ack && pwdata[UHPF_B_IN] && ev_in_received[0]
            |=> s.flag[0][UHPF_B_IN];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("same-cycle event lost to acknowledge");

    property p_apb_answer;
        pce && setup |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one cycle after setup");

    property p_unmapped_err;
        pce && setup && !mapped |=> pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access");

    c_irq_raised: cover property (pce && !irq ##1 irq);
    c_bank_release: cover property (bank_release[0]);
    c_unmapped: cover property (pready && pslverr);
    c_hold_cleared: cover property (pipe_request_hold[0] ##1
                                    !pipe_request_hold[0]);

endmodule // uhpf_pipe_flags

// [test/uhpf_engine_model.sv]
/*
 * far-side model for the pipe flag block: one-cycle event pulses
 * per pipe, as the transaction engine would raise them.
 * assumes the bench calls pulse just after a rising edge.
 */
`timescale 1ns/1ns
module uhpf_engine_model (
    // clock
    input  wire logic       pclk,
    // event pulses, one bit per pipe
    output logic      [6:0] ev_in_received,
    output logic      [6:0] ev_out_free,
    output logic      [6:0] ev_setup_free,
    output logic      [6:0] ev_underflow,
    output logic      [6:0] ev_nak,
    output logic      [6:0] ev_overflow,
    output logic      [6:0] ev_stall,
    output logic      [6:0] ev_crc,
    output logic      [6:0] ev_short,
    output logic      [6:0] ev_busy_bank,
    output logic      [6:0] ev_in_budget_done,
    output logic      [6:0] ev_pipe_reset,
    output logic      [6:0] ev_pipe_enable,
    output logic      [6:0] ev_toggle_restart_done
);
    logic [6:0] ev [14];

    initial begin
        foreach (ev[i]) ev[i] = 7'h00;
    end
    assign ev_in_received         = ev[0];
    assign ev_out_free            = ev[1];
    assign ev_setup_free          = ev[2];
    assign ev_underflow           = ev[3];
    assign ev_nak                 = ev[4];
    assign ev_overflow            = ev[5];
    assign ev_stall               = ev[6];
    assign ev_crc                 = ev[7];
    assign ev_short               = ev[8];
    assign ev_busy_bank           = ev[9];
    assign ev_in_budget_done      = ev[10];
    assign ev_pipe_reset          = ev[11];
    assign ev_pipe_enable         = ev[12];
    assign ev_toggle_restart_done = ev[13];

    // events are single-cycle pulses, never levels
    task pulse(input int k, input int p);
        @(posedge pclk);
        ev[k][p] <= 1'b1;
        @(posedge pclk);
        ev[k][p] <= 1'b0;
    endtask
endmodule // uhpf_engine_model

// [test/tb_usb_host_pipe_flag_control.sv]
/*
 * self-checking bench of the pipe flag block over apb.
 * assumes the engine model for events; pipe 3 is in, pipe 4 control+iso.
 */
`timescale 1ns/1ns
module tb_usb_host_pipe_flag_control
    import uhpf_pkg::*;
;
    logic        pclk, presetn, pce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, irq;
    logic [6:0]  pipe_is_in, pipe_is_control, pipe_is_iso;
    logic [6:0]  pipe_unconfigured, pipe_fault_status, pipe_request_hold;
    logic [6:0]  toggle_restart, bank_release, dma_request_blocked;
    logic [6:0]  ev_in_received, ev_out_free, ev_setup_free, ev_underflow;
    logic [6:0]  ev_nak, ev_overflow, ev_stall, ev_crc, ev_short;
    logic [6:0]  ev_busy_bank, ev_in_budget_done, ev_pipe_reset;
    logic [6:0]  ev_pipe_enable, ev_toggle_restart_done;
    int          error_cnt, n_tests, rel_cnt;

    uhpf_engine_model eng (
        .pclk, .ev_in_received, .ev_out_free, .ev_setup_free,
        .ev_underflow, .ev_nak, .ev_overflow, .ev_stall, .ev_crc,
        .ev_short, .ev_busy_bank, .ev_in_budget_done, .ev_pipe_reset,
        .ev_pipe_enable, .ev_toggle_restart_done
    );
    uhpf_pipe_flags DUT (
        .pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pipe_is_in,
        .pipe_is_control, .pipe_is_iso, .pipe_unconfigured,
        .ev_in_received, .ev_out_free, .ev_setup_free,
        .ev_underflow, .ev_nak, .ev_overflow, .ev_stall, .ev_crc,
        .ev_short, .ev_busy_bank, .ev_in_budget_done, .ev_pipe_reset,
        .ev_pipe_enable, .ev_toggle_restart_done, .pipe_fault_status,
        .pipe_request_hold, .toggle_restart, .bank_release,
        .dma_request_blocked, .irq
    );

    always #50 pclk = ~pclk;

    always @(posedge pclk) begin
        if (bank_release[3] === 1'b1) rel_cnt++;
    end

    // ------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            $display("unexpected %s: expected %h, seen %h", nm, x, g);
            error_cnt++;
        end
    endtask

    function automatic logic [11:0] ad(input logic [11:0] b, input int p);
        return b + UHPF_STRIDE * 12'(p);
    endfunction

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk("pready", 32'h1, 32'(pready));
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b1, d, q, e);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b0, 32'h0, q, e);
        chk(nm, x, q);
    endtask

    task automatic hold_off();
        wr(ad(UHPF_CCLR_BASE, 0), 32'h0002_0000);
        @(negedge pclk);
        chk("hold cleared", 32'h0, 32'(pipe_request_hold[0]));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int p = 0; p < 7; p++) begin
            rdc("view", ad(UHPF_VIEW_BASE, p), 32'h0);
            rdc("status", ad(UHPF_STAT_BASE, p), 32'h0);
        end
        chk("irq idle", 32'h0, 32'(irq));
    endtask

    task automatic t_strobes();
        logic [11:0] sb [4];
        logic [31:0] q;
        logic        e;
        sb = '{UHPF_FORCE_BASE, UHPF_ACK_BASE, UHPF_CSET_BASE,
               UHPF_CCLR_BASE};
        wr(ad(UHPF_CSET_BASE, 0), 32'h1);
        wr(ad(UHPF_FORCE_BASE, 0), 32'h20);
        foreach (sb[i]) wr(ad(sb[i], 0), 32'h0);
        rdc("view kept", ad(UHPF_VIEW_BASE, 0), 32'h1);
        rdc("flags kept", ad(UHPF_STAT_BASE, 0), 32'h20);
        chk("irq other bit", 32'h0, 32'(irq));
        foreach (sb[i]) rdc("strobe read", ad(sb[i], 0), 32'h0);
        apb(12'h700, 1'b0, 32'h0, q, e);
        chk("unmapped error", 32'h1, 32'(e));
        wr(ad(UHPF_CCLR_BASE, 0), 32'h1);
        wr(ad(UHPF_ACK_BASE, 0), 32'h20);
    endtask

    task automatic t_flags();
        int          k [12] = '{0, 1, 2, 3, 2, 4, 5, 6, 7, 7, 8, 9};
        int          p [12] = '{3, 0, 4, 5, 5, 0, 5, 5, 4, 5, 5, 6};
        int          b [12] = '{0, 1, 2, 2, -1, 4, 5, 6, 6, -1, 7, 12};
        logic [31:0] x;
        for (int i = 0; i < 12; i++) begin
            x = (b[i] < 0) ? 32'h0 : 32'h1 << b[i];
            eng.pulse(k[i], p[i]);
            rdc("event flag", ad(UHPF_STAT_BASE, p[i]), x);
            wr(ad(UHPF_ACK_BASE, p[i]), x);
            rdc("acked", ad(UHPF_STAT_BASE, p[i]), x & ~UHPF_ACK_MASK);
        end
    endtask

    task automatic t_irq();
        int          b [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 12};
        logic [31:0] x, st, h;
        st = 32'h0;
        for (int i = 0; i < 9; i++) begin
            x = 32'h1 << b[i];
            h = (i >= 3) ? 32'h0002_0000 : 32'h0;
            wr(ad(UHPF_FORCE_BASE, 1), x);
            rdc("forced", ad(UHPF_STAT_BASE, 1), x | st);
            chk("irq masked", 32'h0, 32'(irq));
            wr(ad(UHPF_CSET_BASE, 1), x);
            rdc("enable", ad(UHPF_VIEW_BASE, 1), x | h);
            chk("irq raised", 32'h1, 32'(irq));
            wr(ad(UHPF_CCLR_BASE, 1), x);
            wr(ad(UHPF_ACK_BASE, 1), x);
            st = st | (x & ~UHPF_ACK_MASK);
        end
    endtask

    task automatic t_dma();
        wr(ad(UHPF_FORCE_BASE, 1), 32'h10);
        wr(ad(UHPF_CSET_BASE, 1), 32'h0001_0010);
        rdc("dma view", ad(UHPF_VIEW_BASE, 1), 32'h0003_0010);
        chk("dma blocked", 32'h1, 32'(dma_request_blocked[1]));
        wr(ad(UHPF_CCLR_BASE, 1), 32'h10);
        rdc("dma view", ad(UHPF_VIEW_BASE, 1), 32'h0003_0000);
        chk("dma free", 32'h0, 32'(dma_request_blocked[1]));
        wr(ad(UHPF_CCLR_BASE, 1), 32'h0001_0000);
    endtask

    task automatic t_handoff();
        rdc("in handoff", ad(UHPF_VIEW_BASE, 3), 32'h4000);
        rdc("setup handoff", ad(UHPF_VIEW_BASE, 4), 32'h4000);
        rdc("out handoff", ad(UHPF_VIEW_BASE, 5), 32'h0002_4000);
        wr(ad(UHPF_CCLR_BASE, 3), 32'h4000);
        rdc("handoff clear", ad(UHPF_VIEW_BASE, 3), 32'h0);
        chk("bank release", 32'h1, 32'(rel_cnt));
    endtask

    task automatic t_hold();
        int k [4] = '{6, 10, 11, 12};
        wr(ad(UHPF_CSET_BASE, 0), 32'h0002_0000);
        @(negedge pclk);
        chk("hold set", 32'h1, 32'(pipe_request_hold[0]));
        hold_off();
        foreach (k[i]) begin
            eng.pulse(k[i], 0);
            @(negedge pclk);
            chk("hold by event", 32'h1, 32'(pipe_request_hold[0]));
            hold_off();
        end
        @(posedge pclk);
        pipe_unconfigured[0] <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("hold unconfigured", 32'h1, 32'(pipe_request_hold[0]));
        pipe_unconfigured[0] <= 1'b0;
        hold_off();
        @(posedge pclk);
        pipe_fault_status[0] <= 1'b1;
        @(posedge pclk);
        rdc("error flag", ad(UHPF_STAT_BASE, 0), 32'h48);
        chk("hold by error", 32'h1, 32'(pipe_request_hold[0]));
        @(posedge pclk);
        pipe_fault_status[0] <= 1'b0;
        hold_off();
        rdc("error gone", ad(UHPF_STAT_BASE, 0), 32'h40);
    endtask

    task automatic t_toggle();
        wr(ad(UHPF_CSET_BASE, 0), 32'h0004_0000);
        @(negedge pclk);
        chk("toggle set", 32'h1, 32'(toggle_restart[0]));
        rdc("toggle view", ad(UHPF_VIEW_BASE, 0), 32'h0004_4000);
        eng.pulse(13, 0);
        @(negedge pclk);
        chk("toggle done", 32'h0, 32'(toggle_restart[0]));
    endtask

    task print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        chk("watchdog", 32'h0, 32'h1);
        print_verdict();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h0;
        pce = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        pipe_is_in = 7'h08;
        pipe_is_control = 7'h10;
        pipe_is_iso = 7'h10;
        pipe_unconfigured = 7'h00;
        pipe_fault_status = 7'h00;
        {error_cnt, n_tests, rel_cnt} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_strobes();
        t_flags();
        t_irq();
        t_dma();
        t_handoff();
        t_hold();
        t_toggle();
        print_verdict();
    end
endmodule // tb_usb_host_pipe_flag_control
